// >>> core/serial_cfg.svh
/*
   Constants for the serial port configuration block: register indices, field positions,
   reset values and timing counts. Assumes a 100 MHz core clock.
*/
`ifndef SERIAL_CFG_SVH
`define SERIAL_CFG_SVH

// Register indices; byte address is four times the index
`define IDX_DEV_SELECT 8'h07
`define IDX_ACTIVATE 8'h30
`define IDX_BASE_HIGH 8'h60
`define IDX_BASE_LOW 8'h61
`define IDX_IRQ_LEVEL 8'h70
`define IDX_MODE_CLOCK 8'hf0
`define IDX_INFRARED 8'hf1
`define IDX_CARD_CLOCK 8'hf2
`define IDX_CARD_DIVISOR 8'hf3

// Logical device numbers of the two ports
`define DEV_PORT1 8'h01
`define DEV_PORT2 8'h02

// Field positions
`define FLD_ENABLE 0
`define FLD_MODE_LSB 4
`define FLD_CLKSRC_LSB 1
`define FLD_IRQ_SHARE 0
`define FLD_NO_TX_DELAY 7
`define FLD_NO_RX_DELAY 6
`define FLD_RX_MASK 5
`define FLD_HALF_DUPLEX 4
`define FLD_RX_POLARITY 3
`define FLD_PFET_POL 2
`define FLD_PSNT_POL 7

// Reset values
`define RST_ACTIVATE 8'h00
`define RST_P1_BASE_HIGH 8'h03
`define RST_P2_BASE_HIGH 8'h02
`define RST_BASE_LOW 8'hf8
`define RST_P1_IRQ 8'h04
`define RST_P2_IRQ 8'h03
`define RST_MODE_CLOCK 8'h00
`define RST_INFRARED 8'h50
`define RST_CARD_CLOCK 8'h00
`define RST_CARD_DIVISOR 8'h7f

// Timing
`define BAUD_DIV_STD 4'hd
`define BAUD_DIV_MUSIC 4'hc
`define TURN_BITS 40
`define OVERSAMPLE 16
`define TURN_TICKS (`TURN_BITS * `OVERSAMPLE)
`define CARD_DIV_3M5 7'h1b
`define CARD_DIV_7M1 7'h0d

`endif

// >>> core/serial_cfg_pkg.sv
/*
   Types for the serial port configuration block.
   Assumes serial_cfg.svh supplies the numeric constants.
*/
package serial_cfg_pkg;

   typedef enum logic [2:0]
   {
      MODE_STANDARD = 3'b000,
      MODE_INFRARED_SERIAL = 3'b001,
      MODE_AMPLITUDE_SHIFT_INFRARED = 3'b010,
      MODE_CARD_READER = 3'b100
   } port_mode_t;

   typedef struct packed
   {
      logic enable;
      logic [3:0] base_high;
      logic [4:0] base_low;
      logic [3:0] irq_level;
      logic [2:0] mode;
      logic [1:0] clock_source;
      logic irq_share;
      logic [4:0] infrared;
      logic pfet_pol;
      logic [1:0] card_clock_select;
      logic psnt_pol;
      logic [6:0] card_clock_divisor;
   } port_cfg_t;

   typedef struct packed
   {
      logic [3:0] baud_cnt;
      logic [3:0] os_cnt;
      logic baud_tick;
      logic tx_prev;
      logic [9:0] tx_hold;
      logic [9:0] rx_hold;
      logic tx_allowed;
      logic rx;
      logic [6:0] card_cnt;
      logic card_tick;
      logic card_present;
      logic card_power;
   } port_run_t;

   typedef struct packed
   {
      logic [7:0] logical_device_number;
      logic ack;
      logic [31:0] dat;
      port_cfg_t [1:0] cfg;
      port_run_t [1:0] run;
   } state_t;

endpackage : serial_cfg_pkg

// >>> core/serial_port_config_regs.sv
/*
   Configuration registers for two serial ports, reached over a classic Wishbone slave,
   plus the small amount of port logic these registers steer.
   Assumes synchronous inputs, a 100 MHz clock and reference ticks for 24 MHz and 96 MHz.
*/
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`include "serial_cfg.svh"

module serial_port_config_regs
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Reference ticks, one cycle each
   input wire logic baud_ref_tick_i,
   input wire logic card_ref_tick_i,
   // Per-port data path side
   input wire logic [1:0] tx_busy_i,
   input wire logic [1:0] rx_i,
   input wire logic [1:0] card_present_in_i,
   input wire logic [1:0] card_power_req_i,
   // Per-port configuration and status
   output logic [1:0] port_enable_o,
   output logic [1:0][15:0] base_addr_o,
   output logic [1:0][3:0] irq_level_o,
   output logic [1:0] irq_share_o,
   output logic [1:0][2:0] mode_o,
   output logic [1:0] half_duplex_o,
   output logic [1:0] baud_tick_o,
   output logic [1:0] tx_allowed_o,
   output logic [1:0] rx_o,
   output logic [1:0] card_clk_tick_o,
   output logic [1:0] card_present_o,
   output logic [1:0] card_power_switch_out_o
);

   serial_cfg_pkg::state_t state_r;
   serial_cfg_pkg::state_t state_nxt;

   logic [7:0] index;
   logic sel_port;
   logic port_hit;
   logic [7:0] rd_byte;

   assign index = adr_i[9:2];
   assign port_hit = (state_r.logical_device_number == `DEV_PORT1) ||
                     (state_r.logical_device_number == `DEV_PORT2);
   assign sel_port = (state_r.logical_device_number == `DEV_PORT2);

   // Read mux; unmapped indices and unknown devices read as zero
   always_comb
   begin
      serial_cfg_pkg::port_cfg_t c;
      c = state_r.cfg[sel_port];
      rd_byte = 8'h00;
      if (index == `IDX_DEV_SELECT)
      begin
         rd_byte = state_r.logical_device_number;
      end
      else if (port_hit)
      begin
         unique case (index)
            `IDX_ACTIVATE: rd_byte = {7'h00, c.enable};
            `IDX_BASE_HIGH: rd_byte = {4'h0, c.base_high};
            `IDX_BASE_LOW: rd_byte = {c.base_low, 3'h0};
            `IDX_IRQ_LEVEL: rd_byte = {4'h0, c.irq_level};
            `IDX_MODE_CLOCK: rd_byte = {1'b0, c.mode, 1'b0, c.clock_source, c.irq_share};
            `IDX_INFRARED: rd_byte = {c.infrared, 3'h0};
            `IDX_CARD_CLOCK: rd_byte = {5'h00, c.pfet_pol, c.card_clock_select};
            `IDX_CARD_DIVISOR: rd_byte = {c.psnt_pol, c.card_clock_divisor};
            default: rd_byte = 8'h00;
         endcase
      end
   end

   always_comb
   begin
      logic wr;
      logic infrared_mode;
      logic card_mode;
      logic [3:0] baud_div;
      logic [6:0] card_div;
      logic tx_rise;
      logic tx_fall;
      wr = 1'b0;
      infrared_mode = 1'b0;
      card_mode = 1'b0;
      baud_div = 4'h0;
      card_div = 7'h00;
      tx_rise = 1'b0;
      tx_fall = 1'b0;
      state_nxt = state_r;

      // Wishbone: one wait state, data and ack from flip-flops, ack dropped next cycle
      state_nxt.ack = 1'b0;
      if (cyc_i && stb_i && !state_r.ack)
      begin
         state_nxt.ack = 1'b1;
         state_nxt.dat = {24'h000000, rd_byte};
      end
      // Write lands at the edge where the master sees ack
      wr = cyc_i && stb_i && we_i && state_r.ack && sel_i[0];
      if (wr && index == `IDX_DEV_SELECT)
      begin
         state_nxt.logical_device_number = dat_i[7:0];
      end
      else if (wr && port_hit)
      begin
         unique case (index)
            `IDX_ACTIVATE: state_nxt.cfg[sel_port].enable = dat_i[`FLD_ENABLE];
            `IDX_BASE_HIGH: state_nxt.cfg[sel_port].base_high = dat_i[3:0];
            `IDX_BASE_LOW: state_nxt.cfg[sel_port].base_low = dat_i[7:3];
            `IDX_IRQ_LEVEL: state_nxt.cfg[sel_port].irq_level = dat_i[3:0];
            `IDX_MODE_CLOCK:
            begin
               state_nxt.cfg[sel_port].mode = dat_i[`FLD_MODE_LSB +: 3];
               state_nxt.cfg[sel_port].clock_source = dat_i[`FLD_CLKSRC_LSB +: 2];
               state_nxt.cfg[sel_port].irq_share = dat_i[`FLD_IRQ_SHARE];
            end
            `IDX_INFRARED: state_nxt.cfg[sel_port].infrared = dat_i[7:3];
            `IDX_CARD_CLOCK:
            begin
               state_nxt.cfg[sel_port].pfet_pol = dat_i[`FLD_PFET_POL];
               state_nxt.cfg[sel_port].card_clock_select = dat_i[1:0];
            end
            `IDX_CARD_DIVISOR:
            begin
               state_nxt.cfg[sel_port].psnt_pol = dat_i[`FLD_PSNT_POL];
               state_nxt.cfg[sel_port].card_clock_divisor = dat_i[6:0];
            end
            default: state_nxt.cfg[sel_port].enable = state_r.cfg[sel_port].enable;
         endcase
      end

      // Port logic; a disabled port produces no ticks and passes nothing
      for (int p = 0; p < 2; p++)
      begin
         infrared_mode = state_r.cfg[p].enable &&
            (state_r.cfg[p].mode == serial_cfg_pkg::MODE_INFRARED_SERIAL ||
             state_r.cfg[p].mode == serial_cfg_pkg::MODE_AMPLITUDE_SHIFT_INFRARED);
         card_mode = state_r.cfg[p].enable &&
            (state_r.cfg[p].mode == serial_cfg_pkg::MODE_CARD_READER);

         // Baud divider; reserved sources stop the tick rather than guess a rate
         unique case (state_r.cfg[p].clock_source)
            2'b00: baud_div = `BAUD_DIV_STD;
            2'b01: baud_div = `BAUD_DIV_MUSIC;
            default: baud_div = 4'h0;
         endcase
         state_nxt.run[p].baud_tick = 1'b0;
         if (!state_r.cfg[p].enable || baud_div == 4'h0)
         begin
            state_nxt.run[p].baud_cnt = 4'h0;
         end
         else if (baud_ref_tick_i)
         begin
            if (state_r.run[p].baud_cnt >= baud_div - 4'h1)
            begin
               state_nxt.run[p].baud_cnt = 4'h0;
               state_nxt.run[p].baud_tick = 1'b1;
            end
            else
            begin
               state_nxt.run[p].baud_cnt = state_r.run[p].baud_cnt + 4'h1;
            end
         end

         // Turnaround delays are counted in oversampling ticks: 16 per bit
         tx_rise = tx_busy_i[p] && !state_r.run[p].tx_prev;
         tx_fall = !tx_busy_i[p] && state_r.run[p].tx_prev;
         state_nxt.run[p].tx_prev = tx_busy_i[p];
         if (tx_rise && infrared_mode && !state_r.cfg[p].infrared[`FLD_NO_TX_DELAY - 3])
         begin
            state_nxt.run[p].tx_hold = 10'(`TURN_TICKS);
         end
         else if (state_r.run[p].tx_hold != 10'h000 && state_r.run[p].baud_tick)
         begin
            state_nxt.run[p].tx_hold = state_r.run[p].tx_hold - 10'h001;
         end
         if (tx_fall && infrared_mode && !state_r.cfg[p].infrared[`FLD_NO_RX_DELAY - 3])
         begin
            state_nxt.run[p].rx_hold = 10'(`TURN_TICKS);
         end
         else if (state_r.run[p].rx_hold != 10'h000 && state_r.run[p].baud_tick)
         begin
            state_nxt.run[p].rx_hold = state_r.run[p].rx_hold - 10'h001;
         end
         if (!infrared_mode)
         begin
            state_nxt.run[p].tx_hold = 10'h000;
            state_nxt.run[p].rx_hold = 10'h000;
         end
         state_nxt.run[p].tx_allowed = state_r.cfg[p].enable && tx_busy_i[p] &&
            (state_nxt.run[p].tx_hold == 10'h000);

         // Receive path: idle level is 1 when masked or delayed
         state_nxt.run[p].rx = rx_i[p] ^
            (infrared_mode && state_r.cfg[p].mode == serial_cfg_pkg::MODE_INFRARED_SERIAL &&
             state_r.cfg[p].infrared[`FLD_RX_POLARITY - 3]);
         if (!state_r.cfg[p].enable ||
             (state_r.cfg[p].infrared[`FLD_RX_MASK - 3] && tx_busy_i[p]) ||
             (state_r.cfg[p].infrared[`FLD_HALF_DUPLEX - 3] && tx_busy_i[p]) ||
             state_nxt.run[p].rx_hold != 10'h000)
         begin
            state_nxt.run[p].rx = 1'b1;
         end

         // Card clock; a zero divisor is treated as stopped
         unique case (state_r.cfg[p].card_clock_select)
            2'b00: card_div = 7'h00;
            2'b01: card_div = `CARD_DIV_3M5;
            2'b10: card_div = `CARD_DIV_7M1;
            2'b11: card_div = state_r.cfg[p].card_clock_divisor;
         endcase
         state_nxt.run[p].card_tick = 1'b0;
         if (!card_mode || card_div == 7'h00)
         begin
            state_nxt.run[p].card_cnt = 7'h00;
         end
         else if (card_ref_tick_i)
         begin
            if (state_r.run[p].card_cnt >= card_div - 7'h01)
            begin
               state_nxt.run[p].card_cnt = 7'h00;
               state_nxt.run[p].card_tick = 1'b1;
            end
            else
            begin
               state_nxt.run[p].card_cnt = state_r.run[p].card_cnt + 7'h01;
            end
         end
         state_nxt.run[p].card_present = card_mode &&
            (card_present_in_i[p] == state_r.cfg[p].psnt_pol);
         // Power switch idles high outside card mode, so the polarity bit has no effect there
         state_nxt.run[p].card_power = card_mode ?
            (card_power_req_i[p] ~^ state_r.cfg[p].pfet_pol) : 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r <= '0;
         state_r.cfg[0].enable <= 1'(`RST_ACTIVATE);
         state_r.cfg[1].enable <= 1'(`RST_ACTIVATE);
         state_r.cfg[0].base_high <= 4'(`RST_P1_BASE_HIGH);
         state_r.cfg[1].base_high <= 4'(`RST_P2_BASE_HIGH);
         state_r.cfg[0].base_low <= 5'(`RST_BASE_LOW >> 3);
         state_r.cfg[1].base_low <= 5'(`RST_BASE_LOW >> 3);
         state_r.cfg[0].irq_level <= 4'(`RST_P1_IRQ);
         state_r.cfg[1].irq_level <= 4'(`RST_P2_IRQ);
         state_r.cfg[0].infrared <= 5'(`RST_INFRARED >> 3);
         state_r.cfg[1].infrared <= 5'(`RST_INFRARED >> 3);
         state_r.cfg[0].card_clock_divisor <= 7'(`RST_CARD_DIVISOR);
         state_r.cfg[1].card_clock_divisor <= 7'(`RST_CARD_DIVISOR);
         state_r.cfg[0].psnt_pol <= 1'(`RST_CARD_DIVISOR >> 7);
         state_r.cfg[1].psnt_pol <= 1'(`RST_CARD_DIVISOR >> 7);
         state_r.run[0].rx <= 1'b1;
         state_r.run[1].rx <= 1'b1;
         state_r.run[0].card_power <= 1'b1;
         state_r.run[1].card_power <= 1'b1;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign dat_o = state_r.dat;
   assign ack_o = state_r.ack;

   // Per-port outputs straight from the state flip-flops
   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_port
         assign port_enable_o[g] = state_r.cfg[g].enable;
         assign base_addr_o[g] = {4'h0, state_r.cfg[g].base_high, state_r.cfg[g].base_low, 3'h0};
         assign irq_level_o[g] = state_r.cfg[g].irq_level;
         assign irq_share_o[g] = state_r.cfg[g].irq_share;
         assign mode_o[g] = state_r.cfg[g].mode;
         assign half_duplex_o[g] = state_r.cfg[g].infrared[`FLD_HALF_DUPLEX - 3];
         assign baud_tick_o[g] = state_r.run[g].baud_tick;
         assign tx_allowed_o[g] = state_r.run[g].tx_allowed;
         assign rx_o[g] = state_r.run[g].rx;
         assign card_clk_tick_o[g] = state_r.run[g].card_tick;
         assign card_present_o[g] = state_r.run[g].card_present;
         assign card_power_switch_out_o[g] = state_r.run[g].card_power;
      end
   endgenerate

endmodule : serial_port_config_regs

// >>> testbench/serial_cfg_checker.sv
/*
   Checker for serial_port_config_regs: bus handshake, port 1 outputs and the base addresses of both ports.
   Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module serial_cfg_checker
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   // Port side
   input wire logic [1:0] tx_busy_i,
   input wire logic [1:0] port_enable_o,
   input wire logic [1:0][15:0] base_addr_o,
   input wire logic [1:0][2:0] mode_o,
   input wire logic [1:0] half_duplex_o,
   input wire logic [1:0] baud_tick_o,
   input wire logic [1:0] tx_allowed_o,
   input wire logic [1:0] rx_o,
   input wire logic [1:0] card_clk_tick_o,
   input wire logic [1:0] card_present_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing after request");
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_high_zero: assert property (base_addr_o[0][15:12] == 4'h0 && base_addr_o[1][15:12] == 4'h0)
      else $error("base address top nibble not zero");
   a_low_zero: assert property (base_addr_o[0][2:0] == 3'h0 && base_addr_o[1][2:0] == 3'h0)
      else $error("base address not eight byte aligned");
   a_idle_off: assert property (!port_enable_o[0] && $past(!port_enable_o[0])
      |-> rx_o[0] && !tx_allowed_o[0] && !baud_tick_o[0])
      else $error("disabled port active");
   a_card_gate: assert property (mode_o[0] != 3'h4 && $past(mode_o[0]) != 3'h4
      |-> !card_clk_tick_o[0] && !card_present_o[0])
      else $error("card outputs outside card mode");
   a_mask_rx: assert property ($past(half_duplex_o[0] && tx_busy_i[0]) |-> rx_o[0])
      else $error("receive not masked in half duplex");
   a_tx_cause: assert property (tx_allowed_o[0] |-> $past(tx_busy_i[0] && port_enable_o[0]))
      else $error("transmit allowed without request");
   a_baud_gap: assert property (baud_tick_o[0] |=> !baud_tick_o[0] [*8])
      else $error("baud ticks too close");

   c_tx: cover property (tx_allowed_o[0]);
   c_card: cover property (card_clk_tick_o[0]);
   c_mask: cover property (half_duplex_o[0] && tx_busy_i[0]);
endmodule : serial_cfg_checker

bind serial_port_config_regs serial_cfg_checker chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .tx_busy_i,
   .port_enable_o, .base_addr_o, .mode_o, .half_duplex_o, .baud_tick_o, .tx_allowed_o, .rx_o,
   .card_clk_tick_o, .card_present_o);

// >>> testbench/test_serial_port_config_regs.sv
/*
   Self-checking bench for serial_port_config_regs: register map, clocks, turnaround, masking.
   Assumes the design header is on the include path.
*/
`timescale 1ns/1ps
`include "serial_cfg.svh"
module test_serial_port_config_regs;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, baud_ref_tick_i, card_ref_tick_i;
   logic [31:0] adr_i, dat_i, dat_o, rd;
   logic [3:0] sel_i;
   logic [1:0] tx_busy_i, rx_i, card_present_in_i, card_power_req_i, port_enable_o, irq_share_o;
   logic [1:0] half_duplex_o, baud_tick_o, tx_allowed_o, rx_o, card_clk_tick_o, card_present_o;
   logic [1:0] card_power_switch_out_o, bdiv;
   logic [1:0][15:0] base_addr_o;
   logic [1:0][3:0] irq_level_o;
   logic [1:0][2:0] mode_o;
   int err_count, n_compared;

   serial_port_config_regs uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
      .ack_o, .baud_ref_tick_i, .card_ref_tick_i, .tx_busy_i, .rx_i, .card_present_in_i, .card_power_req_i,
      .port_enable_o, .base_addr_o, .irq_level_o, .irq_share_o, .mode_o, .half_duplex_o, .baud_tick_o,
      .tx_allowed_o, .rx_o, .card_clk_tick_o, .card_present_o, .card_power_switch_out_o);

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Reference ticks every 3 and 2 cycles keep the 640-tick holds short
   always @(posedge clk_i)
   begin
      bdiv <= (bdiv == 2'h2) ? 2'h0 : bdiv + 2'h1;
      baud_ref_tick_i <= (bdiv == 2'h2);
      card_ref_tick_i <= ~card_ref_tick_i;
   end

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict

   task automatic hang(input string what);
      $display("unexpected timeout on %s", what);
      err_count++;
      print_verdict();
   endtask : hang

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Outputs are read at the edge, before that edge's updates land
   task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {22'h0, idx, 2'h0};
      dat_i <= {24'h0, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1)
      begin
         n++;
         if (n > 20)
            hang("ack");
         @(posedge clk_i);
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   function automatic logic pick(input logic card);
      return card ? card_clk_tick_o[0] : baud_tick_o[0];
   endfunction : pick

   // Reference ticks between two output ticks; 0 when none come
   task automatic gap(input logic card, output int refs);
      int n;
      refs = 0;
      for (n = 0; n < 400 && pick(card) !== 1'b1; n++)
         @(posedge clk_i);
      if (n >= 400)
         return;
      for (n = 0; n < 400; n++)
      begin
         @(posedge clk_i);
         refs += card ? card_ref_tick_i : baud_ref_tick_i;
         if (pick(card) === 1'b1)
            return;
      end
      refs = 0;
   endtask : gap

   task automatic wait_ticks(input logic rxside, output int ticks);
      ticks = 0;
      for (int n = 0; n < 40000; n++)
      begin
         @(posedge clk_i);
         if (rxside ? rx_o[0] === 1'b0 : tx_allowed_o[0] === 1'b1)
            return;
         ticks += baud_tick_o[0];
      end
      hang("turnaround");
   endtask : wait_ticks

   task automatic t_resets;
      logic [7:0] idx [8] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'hf0, 8'hf1, 8'hf2, 8'hf3};
      logic [7:0] p1 [8] = '{8'h00, 8'h03, 8'hf8, 8'h04, 8'h00, 8'h50, 8'h00, 8'h7f};
      logic [7:0] p2 [8] = '{8'h00, 8'h02, 8'hf8, 8'h03, 8'h00, 8'h50, 8'h00, 8'h7f};
      for (int i = 0; i < 8; i++)
      begin
         wb(`IDX_DEV_SELECT, 1'b1, 8'h01);
         wb(idx[i], 1'b0, 8'h00);
         check("port1 reset", rd, {24'h0, p1[i]});
         wb(`IDX_DEV_SELECT, 1'b1, 8'h02);
         wb(idx[i], 1'b0, 8'h00);
         check("port2 reset", rd, {24'h0, p2[i]});
      end
      check("enable after reset", port_enable_o, 2'b00);
      $display("done reset values");
   endtask : t_resets

   task automatic t_fields;
      wb(`IDX_DEV_SELECT, 1'b1, 8'h01);
      wb(`IDX_BASE_HIGH, 1'b1, 8'hff);
      wb(`IDX_BASE_LOW, 1'b1, 8'hff);
      wb(`IDX_IRQ_LEVEL, 1'b1, 8'hff);
      wb(`IDX_ACTIVATE, 1'b1, 8'hff);
      wb(`IDX_BASE_HIGH, 1'b0, 8'h00);
      check("base high", rd, 32'h0f);
      wb(`IDX_BASE_LOW, 1'b0, 8'h00);
      check("base low", rd, 32'hf8);
      wb(`IDX_IRQ_LEVEL, 1'b0, 8'h00);
      check("irq level", rd, 32'h0f);
      check("irq out", irq_level_o[0], 4'hf);
      check("enable", port_enable_o, 2'b01);
      check("base out", base_addr_o[0], 16'h0ff8);
      wb(`IDX_DEV_SELECT, 1'b1, 8'h02);
      wb(`IDX_BASE_HIGH, 1'b1, 8'h05);
      wb(`IDX_DEV_SELECT, 1'b1, 8'h00);
      wb(`IDX_BASE_HIGH, 1'b1, 8'h01);
      check("port2 base", base_addr_o[1], 16'h05f8);
      check("port1 kept", base_addr_o[0], 16'h0ff8);
      wb(`IDX_DEV_SELECT, 1'b1, 8'h01);
      $display("done field masks");
   endtask : t_fields

   task automatic t_modes_clocks;
      logic [2:0] code [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
      logic [7:0] src [3] = '{8'h01, 8'h02, 8'h04};
      int exp [3] = '{13, 12, 0};
      int n;
      for (int i = 0; i < 4; i++)
      begin
         wb(`IDX_MODE_CLOCK, 1'b1, {1'b0, code[i], 4'h0});
         check("mode", mode_o[0], code[i]);
      end
      for (int i = 0; i < 3; i++)
      begin
         wb(`IDX_MODE_CLOCK, 1'b1, src[i]);
         check("irq share", irq_share_o[0], src[i][0]);
         gap(1'b0, n);
         check("baud gap", n, exp[i]);
      end
      $display("done modes and clocks");
   endtask : t_modes_clocks

   task automatic t_mask;
      logic [7:0] cfg [3] = '{8'h20, 8'h00, 8'h10};
      logic m [3] = '{1'b1, 1'b0, 1'b1};
      wb(`IDX_MODE_CLOCK, 1'b1, 8'h00);
      rx_i <= 2'b00;
      tx_busy_i <= 2'b01;
      for (int i = 0; i < 3; i++)
      begin
         wb(`IDX_INFRARED, 1'b1, cfg[i]);
         @(posedge clk_i);
         check("masked rx", rx_o[0], m[i]);
         check("half duplex", half_duplex_o[0], cfg[i][4]);
      end
      tx_busy_i <= 2'b00;
      $display("done receive masking");
   endtask : t_mask

   task automatic t_turn;
      int t;
      wb(`IDX_MODE_CLOCK, 1'b1, 8'h10);
      wb(`IDX_INFRARED, 1'b1, 8'h10);
      tx_busy_i <= 2'b01;
      wait_ticks(1'b0, t);
      check("tx hold", t >= 638 && t <= 642, 1'b1);
      tx_busy_i <= 2'b00;
      wait_ticks(1'b1, t);
      check("rx hold", t >= 638 && t <= 642, 1'b1);
      wb(`IDX_INFRARED, 1'b1, 8'hd0);
      tx_busy_i <= 2'b01;
      repeat (2) @(posedge clk_i);
      check("tx at once", tx_allowed_o[0], 1'b1);
      tx_busy_i <= 2'b00;
      repeat (2) @(posedge clk_i);
      check("rx at once", rx_o[0], 1'b0);
      $display("done turnaround");
   endtask : t_turn

   task automatic t_card;
      int exp [4] = '{27, 13, 5, 0};
      int n;
      wb(`IDX_MODE_CLOCK, 1'b1, 8'h00);
      wb(`IDX_CARD_CLOCK, 1'b1, 8'h05);
      wb(`IDX_CARD_DIVISOR, 1'b1, 8'h85);
      card_present_in_i <= 2'b01;
      card_power_req_i <= 2'b01;
      gap(1'b1, n);
      check("card clock off mode", n, 0);
      check("present off mode", card_present_o[0], 1'b0);
      check("power off mode", card_power_switch_out_o[0], 1'b1);
      wb(`IDX_MODE_CLOCK, 1'b1, 8'h40);
      @(posedge clk_i);
      check("present high", card_present_o[0], 1'b1);
      check("power active high", card_power_switch_out_o[0], 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         wb(`IDX_CARD_CLOCK, 1'b1, {6'h0, 2'(i + 1)});
         gap(1'b1, n);
         check("card gap", n, exp[i]);
      end
      check("power active low", card_power_switch_out_o[0], 1'b0);
      card_present_in_i <= 2'b00;
      wb(`IDX_CARD_DIVISOR, 1'b1, 8'h85);
      check("absent high", card_present_o[0], 1'b0);
      wb(`IDX_CARD_DIVISOR, 1'b1, 8'h05);
      @(posedge clk_i);
      check("present low", card_present_o[0], 1'b1);
      $display("done card clock");
   endtask : t_card

   initial
   begin
      rst_i = 1'b1;
      {cyc_i, stb_i, we_i, baud_ref_tick_i, card_ref_tick_i} = 5'h00;
      adr_i = 32'h0;
      dat_i = 32'h0;
      sel_i = 4'h1;
      bdiv = 2'h0;
      {tx_busy_i, rx_i, card_present_in_i, card_power_req_i} = 8'h00;
      err_count = 0;
      n_compared = 0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_resets();
      t_fields();
      t_modes_clocks();
      t_mask();
      t_turn();
      t_card();
      print_verdict();
   end
endmodule : test_serial_port_config_regs
